// *** hw/core_reset_pkg.sv ***
package core_reset_pkg;

   localparam int ADDR_W = 8;
   localparam int PC_W = 21;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFF_STACK_TOP_UPPER = 8'h00;
   localparam logic [7:0] OFF_STACK_TOP_HIGH = 8'h04;
   localparam logic [7:0] OFF_STACK_TOP_LOW = 8'h08;
   localparam logic [7:0] OFF_RETURN_STACK_POINTER = 8'h0c;
   localparam logic [7:0] OFF_PC_LATCH_UPPER = 8'h10;
   localparam logic [7:0] OFF_PC_LATCH_HIGH = 8'h14;
   localparam logic [7:0] OFF_PC_LOW_BYTE = 8'h18;
   localparam logic [7:0] OFF_TABLE_POINTER_UPPER = 8'h1c;
   localparam logic [7:0] OFF_TABLE_POINTER_HIGH = 8'h20;
   localparam logic [7:0] OFF_TABLE_POINTER_LOW = 8'h24;
   localparam logic [7:0] OFF_TABLE_LATCH = 8'h28;
   localparam logic [7:0] OFF_PRODUCT_HIGH = 8'h2c;
   localparam logic [7:0] OFF_PRODUCT_LOW = 8'h30;
   localparam logic [7:0] OFF_INTERRUPT_CONTROL_MAIN = 8'h34;
   localparam logic [7:0] OFF_INTERRUPT_CONTROL_SECOND = 8'h38;
   localparam logic [7:0] OFF_INTERRUPT_CONTROL_THIRD = 8'h3c;
   localparam logic [7:0] OFF_INDIRECT_POINTER0_HIGH = 8'h40;
   localparam logic [7:0] OFF_INDIRECT_POINTER0_LOW = 8'h44;
   localparam logic [7:0] OFF_WORKING_REGISTER = 8'h48;
   localparam logic [7:0] OFF_INDIRECT_POINTER1_HIGH = 8'h4c;
   localparam logic [7:0] OFF_INDIRECT_POINTER1_LOW = 8'h50;
   localparam logic [7:0] OFF_BANK_SELECT = 8'h54;

   // Reset values
   localparam logic [7:0] RST_INTERRUPT_CONTROL_SECOND = 8'hff;
   localparam logic [7:0] RST_INTERRUPT_CONTROL_THIRD = 8'hc0;

   // Field positions
   localparam int STACK_FULL_BIT = 7;
   localparam int STACK_UNDERFLOW_BIT = 6;
   localparam int GIE_HIGH_BIT = 7;
   localparam int GIE_LOW_BIT = 6;
   localparam int IRQ_CTRL_KEEP_BIT = 0;

   // Interrupt vectors and wake-up step
   localparam logic [20:0] VECTOR_HIGH = 21'h000008;
   localparam logic [20:0] VECTOR_LOW = 21'h000018;
   localparam logic [20:0] PC_STEP = 21'h000002;

   typedef struct packed {
      logic [4:0] stack_top_upper;
      logic [7:0] stack_top_high;
      logic [7:0] stack_top_low;
      logic [1:0] stack_flags;
      logic [4:0] stack_index;
      logic [4:0] pc_latch_upper;
      logic [7:0] pc_latch_high;
      logic [20:0] program_counter;
      logic [5:0] table_pointer_upper;
      logic [7:0] table_pointer_high;
      logic [7:0] table_pointer_low;
      logic [7:0] table_latch;
      logic [7:0] product_high;
      logic [7:0] product_low;
      logic [7:0] interrupt_control_main;
      logic [7:0] interrupt_control_second;
      logic [7:0] interrupt_control_third;
      logic [3:0] indirect_pointer0_high;
      logic [7:0] indirect_pointer0_low;
      logic [7:0] working_register;
      logic [3:0] indirect_pointer1_high;
      logic [7:0] indirect_pointer1_low;
      logic [3:0] bank_select;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } core_state_t;

   typedef struct packed {
      logic por_bor;
      logic other_reset;
      logic wake;
      logic wake_by_irq;
      logic irq_high_priority;
      logic [7:0] wake_flags;
   } reset_cause_t;

endpackage

// *** hw/core_register_reset_init.sv ***
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module core_register_reset_init (
   input wire logic sys_clk,
   input wire logic rst,
   input wire core_reset_pkg::reset_cause_t cause,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [core_reset_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [core_reset_pkg::PC_W-1:0] program_counter
);
   import core_reset_pkg::*;

   core_state_t state_reg;
   core_state_t state_next;

   logic access;
   logic wr;
   logic hit;
   logic [7:0] rd_byte;
   logic [20:0] pc_after;
   logic vector_taken;
   logic [20:0] vector;

   assign access = psel & penable & ~state_reg.pready;
   // A write lands only on the edge that completes the transfer, with pready high
   assign wr = psel & penable & state_reg.pready & pwrite;
   // Address of the instruction after the sleep
   assign pc_after = state_reg.program_counter + PC_STEP;

   always_comb begin
      vector_taken = 1'b0;
      vector = VECTOR_LOW;
      if (cause.wake_by_irq) begin
         if (cause.irq_high_priority &&
             state_reg.interrupt_control_main[GIE_HIGH_BIT]) begin
            vector_taken = 1'b1;
            vector = VECTOR_HIGH;
         end else if (!cause.irq_high_priority &&
                      state_reg.interrupt_control_main[GIE_LOW_BIT]) begin
            vector_taken = 1'b1;
            vector = VECTOR_LOW;
         end
      end
   end

   // Read mux; indirect access locations are not decoded at all
   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         OFF_STACK_TOP_UPPER: rd_byte = {3'h0, state_reg.stack_top_upper};
         OFF_STACK_TOP_HIGH: rd_byte = state_reg.stack_top_high;
         OFF_STACK_TOP_LOW: rd_byte = state_reg.stack_top_low;
         OFF_RETURN_STACK_POINTER: rd_byte = {state_reg.stack_flags, 1'b0,
                                              state_reg.stack_index};
         OFF_PC_LATCH_UPPER: rd_byte = {3'h0, state_reg.pc_latch_upper};
         OFF_PC_LATCH_HIGH: rd_byte = state_reg.pc_latch_high;
         OFF_PC_LOW_BYTE: rd_byte = state_reg.program_counter[7:0];
         OFF_TABLE_POINTER_UPPER: rd_byte = {2'h0, state_reg.table_pointer_upper};
         OFF_TABLE_POINTER_HIGH: rd_byte = state_reg.table_pointer_high;
         OFF_TABLE_POINTER_LOW: rd_byte = state_reg.table_pointer_low;
         OFF_TABLE_LATCH: rd_byte = state_reg.table_latch;
         OFF_PRODUCT_HIGH: rd_byte = state_reg.product_high;
         OFF_PRODUCT_LOW: rd_byte = state_reg.product_low;
         OFF_INTERRUPT_CONTROL_MAIN: rd_byte = state_reg.interrupt_control_main;
         OFF_INTERRUPT_CONTROL_SECOND: rd_byte = state_reg.interrupt_control_second;
         OFF_INTERRUPT_CONTROL_THIRD: rd_byte = state_reg.interrupt_control_third;
         OFF_INDIRECT_POINTER0_HIGH: rd_byte = {4'h0, state_reg.indirect_pointer0_high};
         OFF_INDIRECT_POINTER0_LOW: rd_byte = state_reg.indirect_pointer0_low;
         OFF_WORKING_REGISTER: rd_byte = state_reg.working_register;
         OFF_INDIRECT_POINTER1_HIGH: rd_byte = {4'h0, state_reg.indirect_pointer1_high};
         OFF_INDIRECT_POINTER1_LOW: rd_byte = state_reg.indirect_pointer1_low;
         OFF_BANK_SELECT: rd_byte = {4'h0, state_reg.bank_select};
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      state_next.pready = access;
      state_next.pslverr = access & ~hit;
      state_next.prdata = (access && !pwrite && hit) ? {24'h000000, rd_byte}
                                                      : 32'h00000000;

      if (wr && hit) begin
         case (paddr)
            OFF_STACK_TOP_UPPER: state_next.stack_top_upper = pwdata[4:0];
            OFF_STACK_TOP_HIGH: state_next.stack_top_high = pwdata[7:0];
            OFF_STACK_TOP_LOW: state_next.stack_top_low = pwdata[7:0];
            OFF_RETURN_STACK_POINTER: begin
               state_next.stack_flags = pwdata[7:6];
               state_next.stack_index = pwdata[4:0];
            end
            OFF_PC_LATCH_UPPER: state_next.pc_latch_upper = pwdata[4:0];
            OFF_PC_LATCH_HIGH: state_next.pc_latch_high = pwdata[7:0];
            // Writing the low byte pulls the latches into the counter
            OFF_PC_LOW_BYTE: state_next.program_counter = {state_reg.pc_latch_upper,
                                                           state_reg.pc_latch_high,
                                                           pwdata[7:0]};
            OFF_TABLE_POINTER_UPPER: state_next.table_pointer_upper = pwdata[5:0];
            OFF_TABLE_POINTER_HIGH: state_next.table_pointer_high = pwdata[7:0];
            OFF_TABLE_POINTER_LOW: state_next.table_pointer_low = pwdata[7:0];
            OFF_TABLE_LATCH: state_next.table_latch = pwdata[7:0];
            OFF_PRODUCT_HIGH: state_next.product_high = pwdata[7:0];
            OFF_PRODUCT_LOW: state_next.product_low = pwdata[7:0];
            OFF_INTERRUPT_CONTROL_MAIN: state_next.interrupt_control_main = pwdata[7:0];
            OFF_INTERRUPT_CONTROL_SECOND: state_next.interrupt_control_second = pwdata[7:0];
            OFF_INTERRUPT_CONTROL_THIRD: state_next.interrupt_control_third = pwdata[7:0];
            OFF_INDIRECT_POINTER0_HIGH: state_next.indirect_pointer0_high = pwdata[3:0];
            OFF_INDIRECT_POINTER0_LOW: state_next.indirect_pointer0_low = pwdata[7:0];
            OFF_WORKING_REGISTER: state_next.working_register = pwdata[7:0];
            OFF_INDIRECT_POINTER1_HIGH: state_next.indirect_pointer1_high = pwdata[3:0];
            OFF_INDIRECT_POINTER1_LOW: state_next.indirect_pointer1_low = pwdata[7:0];
            OFF_BANK_SELECT: state_next.bank_select = pwdata[3:0];
            default: state_next.bank_select = state_reg.bank_select;
         endcase
      end

      // Qualifiers outrank software; power-on beats other reset beats wake
      if (cause.por_bor || cause.other_reset) begin
         state_next.stack_top_upper = 5'h00;
         state_next.stack_top_high = 8'h00;
         state_next.stack_top_low = 8'h00;
         state_next.stack_index = 5'h00;
         if (cause.por_bor) begin
            state_next.stack_flags = 2'h0;
         end
         state_next.pc_latch_upper = 5'h00;
         state_next.pc_latch_high = 8'h00;
         state_next.program_counter = 21'h000000;
         state_next.table_pointer_upper = 6'h00;
         state_next.table_pointer_high = 8'h00;
         state_next.table_pointer_low = 8'h00;
         state_next.table_latch = 8'h00;
         // Undefined-on-power-on registers are simply left as they are
         state_next.interrupt_control_main =
            {7'h00, state_reg.interrupt_control_main[IRQ_CTRL_KEEP_BIT]};
         state_next.interrupt_control_second = RST_INTERRUPT_CONTROL_SECOND;
         state_next.interrupt_control_third = RST_INTERRUPT_CONTROL_THIRD;
         state_next.bank_select = 4'h0;
      end else if (cause.wake) begin
         // Watchdog wake touches only the counter, the top stack bit and the wake flags in interrupt_control_main
         state_next.stack_top_upper = {1'b0, state_reg.stack_top_upper[3:0]};
         state_next.program_counter = pc_after;
         state_next.interrupt_control_main =
            state_reg.interrupt_control_main | cause.wake_flags;
         if (vector_taken) begin
            state_next.stack_top_upper = pc_after[20:16];
            state_next.stack_top_high = pc_after[15:8];
            state_next.stack_top_low = pc_after[7:0];
            state_next.stack_index = state_reg.stack_index + 5'h01;
            state_next.program_counter = vector;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.interrupt_control_second <= RST_INTERRUPT_CONTROL_SECOND;
         state_reg.interrupt_control_third <= RST_INTERRUPT_CONTROL_THIRD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign program_counter = state_reg.program_counter;

endmodule // core_register_reset_init

`default_nettype wire

// *** test/core_reset_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_reset_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire core_reset_pkg::reset_cause_t cause,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [core_reset_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [core_reset_pkg::PC_W-1:0] program_counter
);
   import core_reset_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire rs = cause.por_bor | cause.other_reset;
   sequence irq_wake_s(hi);
      cause.wake && cause.wake_by_irq && !rs && cause.irq_high_priority == hi;
   endsequence
   apb_answer_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held");
   slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   reset_pc_clear_a: assert property (rs |=> program_counter == '0)
      else $error("pc not cleared");
   dog_wake_step_a: assert property (cause.wake && !cause.wake_by_irq && !rs
      |=> program_counter == $past(program_counter) + PC_STEP) else $error("pc step");
   irq_high_vec_a: assert property (irq_wake_s(1'b1) |=> program_counter == VECTOR_HIGH
      || program_counter == $past(program_counter) + PC_STEP) else $error("high vector");
   irq_low_vec_a: assert property (irq_wake_s(1'b0) |=> program_counter == VECTOR_LOW
      || program_counter == $past(program_counter) + PC_STEP) else $error("low vector");
   pc_quiet_hold_a: assert property (!rs && !cause.wake && !(psel && pwrite
      && paddr == OFF_PC_LOW_BYTE) |=> $stable(program_counter)) else $error("pc moved");
endmodule // core_reset_monitor
bind core_register_reset_init core_reset_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
   .cause(cause), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .program_counter(program_counter));
`default_nettype wire

// *** test/core_register_reset_init_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_register_reset_init_bench;
   import core_reset_pkg::*;
   localparam logic [21:0] CLR = 22'h2007b7;
   // Stack pointer flags are written too, so other resets show that they are kept
   localparam logic [7:0] WM [22] = '{8'h1f, 8'hff, 8'hff, 8'hdf, 8'h1f, 8'hff, 8'hff,
      8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff,
      8'h0f, 8'hff, 8'h0f};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   reset_cause_t cause = '0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [PC_W-1:0] program_counter;
   logic [7:0] m [22];
   logic [20:0] pc_m = 21'h0;
   int n_errors = 0, n_compared = 0, cycles = 0;
   int seed = 32'h9c8d52b5;
   core_register_reset_init u_dut (.sys_clk(sys_clk), .rst(rst), .cause(cause), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .program_counter(program_counter));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // Ready and the answer are taken at the rising edge that completes the transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [7:0] v);
      apb(1'b1, 8'(i * 4), {24'h0, v & WM[i]});
      if (i == 6) pc_m = {m[4][4:0], m[5], v};
      else m[i] = v & WM[i];
   endtask
   task automatic check_all();
      for (int i = 0; i < 22; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk({24'h0, (i == 6 ? pc_m[7:0] : m[i])}, rd);
         chk(32'h0, {31'h0, er});
      end
      chk({11'h0, pc_m}, {11'h0, program_counter});
   endtask
   task automatic pulse(input reset_cause_t c);
      logic vec;
      vec = c.wake_by_irq && (c.irq_high_priority ? m[13][7] : m[13][6]);
      @(posedge sys_clk);
      cause <= c;
      @(posedge sys_clk);
      cause <= '0;
      if (c.por_bor || c.other_reset) begin
         for (int i = 0; i < 22; i++) if (CLR[i]) m[i] = 8'h00;
         m[3] = c.por_bor ? 8'h00 : m[3] & 8'hc0;
         m[13] = m[13] & 8'h01;
         m[14] = 8'hff;
         m[15] = 8'hc0;
         pc_m = 21'h0;
      end else if (vec) begin
         {m[0], m[1], m[2]} = {3'h0, pc_m + 21'h2};
         m[3][4:0] = m[3][4:0] + 5'h1;
         pc_m = c.irq_high_priority ? VECTOR_HIGH : VECTOR_LOW;
         m[13] = m[13] | c.wake_flags;
      end else begin
         pc_m = pc_m + 21'h2;
         m[0][4] = 1'b0;
         m[13] = m[13] | c.wake_flags;
      end
   endtask
   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      reset_cause_t c;
      for (int i = 0; i < 22; i++) m[i] = 8'h00;
      m[14] = 8'hff;
      m[15] = 8'hc0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      check_all();
      apb(1'b0, 8'h58, 32'h0);
      chk(32'h1, {31'h0, er});
      // Kinds: other reset, power-on, watchdog, irq without and with enable, reset beats wake
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 22; i++) wr(i, 8'($random(seed)));
         if (k > 2 && k < 7) wr(13, {k > 4, k > 4, 6'($random(seed))});
         c = '0;
         c.other_reset = (k == 0 || k == 7);
         c.por_bor = (k == 1);
         c.wake = (k > 1);
         c.wake_by_irq = (k > 2 && k < 7);
         c.irq_high_priority = k[0];
         c.wake_flags = (8'($random(seed)) & 8'h3f) | 8'h01;
         pulse(c);
         check_all();
      end
      complete_run();
   end
endmodule // core_register_reset_init_bench
`default_nettype wire
